// >>> core/rtcsp_defs.vh
/*
 constants of the clock/RAM serial slave port: address map wrap points,
 control byte field positions, reset values and internal latencies.
 assumes it is included by bare name from the core/ design files.
*/
`ifndef RTCSP_DEFS_VH
`define RTCSP_DEFS_VH

// address byte layout
`define RTCSP_DIR_BIT       7
`define RTCSP_DIR_READ      1'b0
`define RTCSP_DIR_WRITE     1'b1

// pointer wrap points, low seven bits of the address
`define RTCSP_CLK_WRAP      7'h1f
`define RTCSP_CLK_BASE      7'h00
`define RTCSP_RAM_WRAP      7'h7f
`define RTCSP_RAM_BASE      7'h20
`define RTCSP_PTR_STEP      7'h01

// control register write address and its lock bit
`define RTCSP_CTRL_WR_ADDR  8'h8f
`define RTCSP_WP_BIT        6
`define RTCSP_WP_RESET      1'b1

// bit counter
`define RTCSP_BIT_LAST      3'h7
`define RTCSP_BIT_ZERO      3'h0
`define RTCSP_BIT_STEP      3'h1

// cycles from a new read address to sampling the read data
`define RTCSP_RD_LAT        2'h2

// write buffer shape
`define RTCSP_FIFO_WIDTH    16
`define RTCSP_FIFO_DEPTH    16
`define RTCSP_FIFO_AW       4

`endif

// >>> core/rtcsp_fifo.v
/*
 synchronous flip-flop FIFO with valid/ready on both sides.
 assumes one clock, an active-low asynchronous reset and a clock enable
 that freezes all state.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcsp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	input  wire             ref_clk,
	input  wire             nrst,
	input  wire             clkEn,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);

	localparam integer  LAST_INT = DEPTH - 1;
	localparam [AW:0]   FULL_CNT = DEPTH[AW:0];
	localparam [AW-1:0] LAST_IDX = LAST_INT[AW-1:0];
	localparam [AW:0]   CNT_ONE  = {{AW{1'b0}}, 1'b1};
	localparam [AW-1:0] IDX_ONE  = CNT_ONE[AW-1:0];

	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_ff;
	reg [AW-1:0]    rdPtr_ff;
	reg [AW:0]      count_ff;

	wire push;
	wire pop;

	// depth need not be a power of two; a one-bit index must still work
	function [AW-1:0] incPtr;
		input [AW-1:0] p;
		begin
			incPtr = (p == LAST_IDX) ? {AW{1'b0}} : p + IDX_ONE;
		end
	endfunction

	assign inReady  = (count_ff != FULL_CNT);
	assign outValid = (count_ff != {(AW+1){1'b0}});
	assign outData  = mem_ff[rdPtr_ff];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// storage carries no reset; only the pointers define its contents
	always @(posedge ref_clk) begin
		if (clkEn && push) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_ff <= {AW{1'b0}};
			rdPtr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else if (clkEn) begin
			if (push) begin
				wrPtr_ff <= incPtr(wrPtr_ff);
			end
			if (pop) begin
				rdPtr_ff <= incPtr(rdPtr_ff);
			end
			if (push && !pop) begin
				count_ff <= count_ff + CNT_ONE;
			end else if (pop && !push) begin
				count_ff <= count_ff - CNT_ONE;
			end
		end
	end

endmodule // rtcsp_fifo

`default_nettype wire

// >>> core/rtcsp_serial_port.v
/*
 serial slave port of a clock/RAM device: frames on chip select, decodes the
 address byte, streams data bytes with an auto-wrapping pointer, in four-wire
 or three-wire mode.
 assumes pins are asynchronous to ref_clk and run far slower (sclk at most a
 few MHz); write data leaves through a FIFO toward the register/RAM store,
 read data is returned by that store on rdData within two cycles of rdAddr.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtcsp_defs.vh"

module rtcsp_serial_port #(
	parameter FIFO_DEPTH = `RTCSP_FIFO_DEPTH,
	parameter FIFO_AW    = `RTCSP_FIFO_AW
)(
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       clkEn,
	input  wire       interfaceSelectPin,
	input  wire       chipSel,
	input  wire       sclk,
	input  wire       serialInLine,
	output wire       serialOutLine,
	output wire       serialOutEn_n,
	output wire       wrValid,
	input  wire       wrReady,
	output wire [7:0] wrAddr,
	output wire [7:0] wrData,
	output wire [7:0] rdAddr,
	output wire       rdStrobe,
	input  wire [7:0] rdData,
	output wire       wpLock,
	output wire       frameActive,
	output wire       fourWireMode,
	output wire       wrOverrun
);

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_DATA = 3'h4;

	// pin synchronisers: bit 0 sclk, 1 chip select, 2 data in, 3 strap
	reg [3:0]  syncA_ff;
	reg [3:0]  syncB_ff;
	reg        prevSclk_ff;
	reg        prevCs_ff;

	reg [2:0]  state_ff;
	reg [2:0]  bitCnt_ff;
	reg [7:0]  rxSr_ff;
	reg [7:0]  txSr_ff;
	reg        outBit_ff;
	reg        dir_ff;
	reg [6:0]  ptr_ff;
	reg        fourWire_ff;
	reg        cpol_ff;
	reg [7:0]  rdAddr_ff;
	reg        rdStrobe_ff;
	reg [1:0]  loadCnt_ff;
	reg        wp_ff;
	reg        pendValid_ff;
	reg [15:0] pendWord_ff;
	reg        overrun_ff;

	reg [2:0]  nxt_state;
	reg [2:0]  nxt_bitCnt;
	reg [7:0]  nxt_rxSr;
	reg [7:0]  nxt_txSr;
	reg        nxt_outBit;
	reg        nxt_dir;
	reg [6:0]  nxt_ptr;
	reg        nxt_fourWire;
	reg        nxt_cpol;
	reg [7:0]  nxt_rdAddr;
	reg        nxt_rdStrobe;
	reg [1:0]  nxt_loadCnt;
	reg        nxt_wp;
	reg        nxt_pendValid;
	reg [15:0] nxt_pendWord;
	reg        nxt_overrun;

	wire       sclkS;
	wire       csS;
	wire       sinS;
	wire       modeS;
	wire       sclkRise;
	wire       sclkFall;
	wire       csRise;
	wire       csFall;
	wire       strobeEdge;
	wire       shiftEdge;
	wire [7:0] rxNext;
	wire       byteDone;
	wire [7:0] wrByteAddr;
	wire       fifoInReady;
	wire [15:0] fifoOut;

	// both wrap points live in the low seven bits; direction rides above
	function [6:0] nextPtr;
		input [6:0] p;
		begin
			if (p == `RTCSP_CLK_WRAP) begin
				nextPtr = `RTCSP_CLK_BASE;
			end else if (p == `RTCSP_RAM_WRAP) begin
				nextPtr = `RTCSP_RAM_BASE;
			end else begin
				nextPtr = p + `RTCSP_PTR_STEP;
			end
		end
	endfunction

	assign sclkS = syncB_ff[0];
	assign csS   = syncB_ff[1];
	assign sinS  = syncB_ff[2];
	assign modeS = syncB_ff[3];

	assign sclkRise = sclkS & ~prevSclk_ff;
	assign sclkFall = ~sclkS & prevSclk_ff;
	assign csRise   = csS & ~prevCs_ff;
	assign csFall   = ~csS & prevCs_ff;

	// idle-high four-wire and three-wire both strobe on the rising edge
	assign strobeEdge = (~fourWire_ff | cpol_ff) ? sclkRise : sclkFall;
	assign shiftEdge  = (~fourWire_ff | cpol_ff) ? sclkFall : sclkRise;

	assign rxNext   = fourWire_ff ? {rxSr_ff[6:0], sinS} : {sinS, rxSr_ff[7:1]};
	assign byteDone = strobeEdge & (bitCnt_ff == `RTCSP_BIT_LAST);
	assign wrByteAddr = {`RTCSP_DIR_WRITE, ptr_ff};

	// sync lag means the line releases a few cycles after chip select falls
	assign serialOutEn_n = ~((state_ff == ST_DATA) & (dir_ff == `RTCSP_DIR_READ) & csS);
	assign serialOutLine = outBit_ff;
	assign rdAddr        = rdAddr_ff;
	assign rdStrobe      = rdStrobe_ff;
	assign wpLock        = wp_ff;
	assign frameActive   = (state_ff != ST_IDLE);
	assign fourWireMode  = fourWire_ff;
	assign wrOverrun     = overrun_ff;
	assign wrAddr        = fifoOut[15:8];
	assign wrData        = fifoOut[7:0];

	always @* begin
		nxt_state     = state_ff;
		nxt_bitCnt    = bitCnt_ff;
		nxt_rxSr      = rxSr_ff;
		nxt_txSr      = txSr_ff;
		nxt_outBit    = outBit_ff;
		nxt_dir       = dir_ff;
		nxt_ptr       = ptr_ff;
		nxt_fourWire  = fourWire_ff;
		nxt_cpol      = cpol_ff;
		nxt_rdAddr    = rdAddr_ff;
		nxt_rdStrobe  = 1'b0;
		nxt_loadCnt   = loadCnt_ff;
		nxt_wp        = wp_ff;
		nxt_pendValid = pendValid_ff;
		nxt_pendWord  = pendWord_ff;
		nxt_overrun   = overrun_ff;

		// pending write drains first so a new byte in the same cycle wins
		if (pendValid_ff && fifoInReady) begin
			nxt_pendValid = 1'b0;
		end

		// read data sampled once the store has had time to answer
		if (loadCnt_ff != 2'h0) begin
			nxt_loadCnt = loadCnt_ff - 2'h1;
			if (loadCnt_ff == 2'h1) begin
				nxt_txSr = rdData;
			end
		end

		case (state_ff)
			ST_IDLE: begin
				if (csRise) begin
					nxt_state    = ST_ADDR;
					nxt_bitCnt   = `RTCSP_BIT_ZERO;
					nxt_fourWire = modeS;
					nxt_cpol     = sclkS;
					nxt_overrun  = 1'b0;
				end
			end
			ST_ADDR: begin
				if (csFall) begin
					nxt_state = ST_IDLE;
				end else if (strobeEdge) begin
					nxt_rxSr   = rxNext;
					nxt_bitCnt = bitCnt_ff + `RTCSP_BIT_STEP;
					if (byteDone) begin
						nxt_state = ST_DATA;
						nxt_dir   = rxNext[`RTCSP_DIR_BIT];
						nxt_ptr   = rxNext[6:0];
						if (rxNext[`RTCSP_DIR_BIT] == `RTCSP_DIR_READ) begin
							nxt_rdAddr   = {`RTCSP_DIR_READ, rxNext[6:0]};
							nxt_rdStrobe = 1'b1;
							nxt_loadCnt  = `RTCSP_RD_LAT;
						end
					end
				end
			end
			ST_DATA: begin
				if (csFall) begin
					nxt_state = ST_IDLE;
				end else begin
					if (strobeEdge) begin
						nxt_rxSr   = rxNext;
						nxt_bitCnt = bitCnt_ff + `RTCSP_BIT_STEP;
					end
					if (byteDone) begin
						nxt_ptr = nextPtr(ptr_ff);
						if (dir_ff == `RTCSP_DIR_WRITE) begin
							// lock blocks everything; only the lock bit itself may drop
							if (wrByteAddr == `RTCSP_CTRL_WR_ADDR) begin
								nxt_wp = rxNext[`RTCSP_WP_BIT];
							end
							if (!wp_ff) begin
								if (pendValid_ff && !fifoInReady) begin
									nxt_overrun = 1'b1;
								end else begin
									nxt_pendValid = 1'b1;
									nxt_pendWord  = {wrByteAddr, rxNext};
								end
							end
						end else begin
							nxt_rdAddr   = {`RTCSP_DIR_READ, nextPtr(ptr_ff)};
							nxt_rdStrobe = 1'b1;
							nxt_loadCnt  = `RTCSP_RD_LAT;
						end
					end
					if (shiftEdge && (dir_ff == `RTCSP_DIR_READ)) begin
						nxt_outBit = fourWire_ff ? txSr_ff[7] : txSr_ff[0];
						nxt_txSr   = fourWire_ff ? {txSr_ff[6:0], 1'b0} : {1'b0, txSr_ff[7:1]};
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// first stage feeds only the second stage
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syncA_ff    <= 4'h0;
			syncB_ff    <= 4'h0;
			prevSclk_ff <= 1'b0;
			prevCs_ff   <= 1'b0;
		end else if (clkEn) begin
			syncA_ff    <= {interfaceSelectPin, serialInLine, chipSel, sclk};
			syncB_ff    <= syncA_ff;
			prevSclk_ff <= syncB_ff[0];
			prevCs_ff   <= syncB_ff[1];
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff     <= ST_IDLE;
			bitCnt_ff    <= `RTCSP_BIT_ZERO;
			rxSr_ff      <= 8'h00;
			txSr_ff      <= 8'h00;
			outBit_ff    <= 1'b0;
			dir_ff       <= `RTCSP_DIR_READ;
			ptr_ff       <= 7'h00;
			fourWire_ff  <= 1'b0;
			cpol_ff      <= 1'b0;
			rdAddr_ff    <= 8'h00;
			rdStrobe_ff  <= 1'b0;
			loadCnt_ff   <= 2'h0;
			wp_ff        <= `RTCSP_WP_RESET;
			pendValid_ff <= 1'b0;
			pendWord_ff  <= 16'h0000;
			overrun_ff   <= 1'b0;
		end else if (clkEn) begin
			state_ff     <= nxt_state;
			bitCnt_ff    <= nxt_bitCnt;
			rxSr_ff      <= nxt_rxSr;
			txSr_ff      <= nxt_txSr;
			outBit_ff    <= nxt_outBit;
			dir_ff       <= nxt_dir;
			ptr_ff       <= nxt_ptr;
			fourWire_ff  <= nxt_fourWire;
			cpol_ff      <= nxt_cpol;
			rdAddr_ff    <= nxt_rdAddr;
			rdStrobe_ff  <= nxt_rdStrobe;
			loadCnt_ff   <= nxt_loadCnt;
			wp_ff        <= nxt_wp;
			pendValid_ff <= nxt_pendValid;
			pendWord_ff  <= nxt_pendWord;
			overrun_ff   <= nxt_overrun;
		end
	end

	// buffer lets the store stall for up to FIFO_DEPTH words plus the pending one; a further byte is dropped and flagged on wrOverrun
	rtcsp_fifo #(
		.WIDTH (`RTCSP_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_wrFifo (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.clkEn    (clkEn),
		.inValid  (pendValid_ff),
		.inReady  (fifoInReady),
		.inData   (pendWord_ff),
		.outValid (wrValid),
		.outReady (wrReady),
		.outData  (fifoOut)
	);

endmodule // rtcsp_serial_port

`default_nettype wire

// >>> testbench/rtcsp_master_model.sv
/*
 serial bus master model: drives chip select, shift clock and the data line.
 assumes the bench calls start, xfer and stop between clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcsp_master_model (
	input  wire logic threeWire,
	input  wire logic serialOutLine,
	input  wire logic serialOutEn_n,
	output var logic  chipSel,
	output var logic  sclk,
	output wire logic serialInLine
);
	localparam real HALF = 62.5;
	logic mDat;
	initial begin
		chipSel = 1'b0;
		sclk = 1'b0;
		mDat = 1'b0;
	end
	// shared line: device wins while it drives, else our own bit
	assign serialInLine = (threeWire && !serialOutEn_n) ? serialOutLine : mDat;
	// clock held at idle level before select rises
	task automatic start(input logic idle);
		sclk = idle;
		#HALF chipSel = 1'b1;
		#(4 * HALF);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int b;
		for (int i = 0; i < 8; i++) begin
			b = threeWire ? i : 7 - i;
			if (!threeWire)
				sclk = ~sclk;
			mDat = tx[b];
			#HALF sclk = ~sclk;
			// released line reads as the inverse of our last bit
			rx[b] = serialOutEn_n ? ~mDat : serialOutLine;
			#HALF if (threeWire) sclk = ~sclk;
		end
	endtask
	task automatic stop();
		#HALF chipSel = 1'b0;
		mDat = ~mDat;
		#(2 * HALF);
	endtask
endmodule // rtcsp_master_model

`default_nettype wire

// >>> testbench/rtcsp_serial_port_monitor.sv
/*
 concurrent checks on the serial port's pins and store side.
 assumes clkEn drops only while no frame runs; bound by the statement at the foot.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcsp_serial_port_monitor (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       interfaceSelectPin,
	input wire logic       chipSel,
	input wire logic       serialOutEn_n,
	input wire logic       wrValid,
	input wire logic       wrReady,
	input wire logic [7:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdAddr,
	input wire logic       rdStrobe,
	input wire logic       frameActive,
	input wire logic       fourWireMode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [6:0] lastPtr_ff;
	logic       seenRd_ff;
	wire  [6:0] expPtr;
	// wrap decided on low seven bits only
	assign expPtr = (lastPtr_ff == 7'h1f) ? 7'h00 : (lastPtr_ff == 7'h7f) ? 7'h20 : lastPtr_ff + 7'h01;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seenRd_ff <= 1'b0;
			lastPtr_ff <= 7'h00;
		end else if (!frameActive) begin
			seenRd_ff <= 1'b0;
		end else if (rdStrobe) begin
			seenRd_ff <= 1'b1;
			lastPtr_ff <= rdAddr[6:0];
		end
	end
	// sync lag of a few cycles, so six idle samples
	sequence csIdle;
		!chipSel [*6];
	endsequence
	sequence frameUp;
		frameActive [*3];
	endsequence
	a_hiz_idle: assert property (csIdle |-> serialOutEn_n) else $error("pin driven while idle");
	a_frame_open: assert property ($rose(chipSel) |-> ##[1:5] frameActive) else $error("no frame");
	a_frame_close: assert property ($fell(chipSel) |-> ##[1:5] !frameActive) else $error("frame stuck");
	a_mode_strap: assert property (frameUp |-> fourWireMode == interfaceSelectPin) else $error("bad mode");
	a_rd_dir: assert property (rdStrobe |-> !rdAddr[7] && frameActive) else $error("bad read");
	a_wr_dir: assert property (wrValid |-> wrAddr[7]) else $error("bad write address");
	a_ptr_step: assert property (rdStrobe && seenRd_ff |-> rdAddr[6:0] == expPtr) else $error("bad step");
	a_wr_hold: assert property (wrValid && !wrReady |=> wrValid && $stable({wrAddr, wrData})) else $error("word lost");
endmodule // rtcsp_serial_port_monitor

bind rtcsp_serial_port rtcsp_serial_port_monitor rtcsp_serial_port_monitor_i (.ref_clk(ref_clk), .nrst(nrst),
	.interfaceSelectPin(interfaceSelectPin), .chipSel(chipSel), .serialOutEn_n(serialOutEn_n), .wrValid(wrValid),
	.wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr), .rdStrobe(rdStrobe),
	.frameActive(frameActive), .fourWireMode(fourWireMode));

`default_nettype wire

// >>> testbench/tb.sv
/*
 self-checking bench: master model on the pins, small store on the store side.
 assumes the monitor binds itself; fifo shrunk to two words for back-pressure.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic            ref_clk = 1'b0;
	logic            nrst = 1'b0;
	logic            clkEn = 1'b1;
	logic            interfaceSelectPin = 1'b1;
	logic            wrReady = 1'b0;
	logic            stall = 1'b1;
	logic            cpol = 1'b1;
	logic [31:0]     rng = 32'he888;
	logic [7:0]      mem [0:127];
	logic [7:0]      shadow [0:127];
	logic [15:0]     wq [$];
	logic [7:0]      aq [$];
	int              errCount = 0;
	int              nTests = 0;
	wire logic       chipSel, sclk, serialInLine, serialOutLine, serialOutEn_n, wrValid, rdStrobe;
	wire logic       wpLock, frameActive, fourWireMode, wrOverrun;
	wire logic [7:0] wrAddr, wrData, rdAddr, rdData;

	assign rdData = mem[rdAddr[6:0]];
	rtcsp_serial_port #(.FIFO_DEPTH(2), .FIFO_AW(1)) rtcsp_serial_port_i (.ref_clk(ref_clk), .nrst(nrst),
		.clkEn(clkEn), .interfaceSelectPin(interfaceSelectPin), .chipSel(chipSel), .sclk(sclk),
		.serialInLine(serialInLine), .serialOutLine(serialOutLine), .serialOutEn_n(serialOutEn_n),
		.wrValid(wrValid), .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData), .rdAddr(rdAddr),
		.rdStrobe(rdStrobe), .rdData(rdData), .wpLock(wpLock), .frameActive(frameActive),
		.fourWireMode(fourWireMode), .wrOverrun(wrOverrun));
	rtcsp_master_model rtcsp_master_model_i (.threeWire(!interfaceSelectPin), .serialOutLine(serialOutLine),
		.serialOutEn_n(serialOutEn_n), .chipSel(chipSel), .sclk(sclk), .serialInLine(serialInLine));

	initial forever #4 ref_clk = ~ref_clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// random store stalls; 1.25 ns keeps link edges off ref_clk edges
	always @(posedge ref_clk) begin
		#1.25;
		rng = xs(rng);
		wrReady = !stall && rng[3];
	end

	// store side: pops and read strobes meet the oldest note
	always @(posedge ref_clk) begin
		if (clkEn && wrValid === 1'b1 && wrReady) begin
			mem[wrAddr[6:0]] <= wrData;
			check({wrAddr, wrData}, wq.pop_front());
		end
		if (rdStrobe === 1'b1)
			check({8'h00, rdAddr}, {8'h00, aq.pop_front()});
	end

	task automatic frame(input logic [7:0] addr, input int n, input int keep, input logic [7:0] seed);
		logic [6:0] p;
		logic [6:0] q;
		logic [7:0] d;
		logic [7:0] r;
		p = addr[6:0];
		@(posedge ref_clk);
		#1.25;
		if (!addr[7])
			aq.push_back({1'b0, p});
		rtcsp_master_model_i.start(interfaceSelectPin & cpol);
		rtcsp_master_model_i.xfer(addr, r);
		for (int i = 0; i < n; i++) begin
			q = (p == 7'h1f) ? 7'h00 : (p == 7'h7f) ? 7'h20 : p + 7'h01;
			d = seed + i[7:0];
			if (!addr[7])
				aq.push_back({1'b0, q});
			else if (i < keep) begin
				wq.push_back({1'b1, p, d});
				shadow[p] = d;
			end
			rtcsp_master_model_i.xfer(addr[7] ? d : 8'haa, r);
			if (!addr[7])
				check({8'h00, r}, {8'h00, shadow[p]});
			p = q;
		end
		rtcsp_master_model_i.stop();
	endtask

	task automatic drain();
		for (int k = 0; k < 4000 && wq.size() > 0; k++)
			@(posedge ref_clk);
		if (wq.size() > 0) begin
			errCount++;
			end_of_test();
		end
	endtask

	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'h3c ^ i[7:0];
			shadow[i] = 8'h3c ^ i[7:0];
		end
		repeat (4) @(posedge ref_clk);
		#1.25 nrst = 1'b1;
		check({15'h0000, wpLock}, 16'h0001);
		frame(8'h85, 1, 0, 8'h11);
		frame(8'h8f, 1, 0, 8'h00);
		check({15'h0000, wpLock}, 16'h0000);
		stall = 1'b0;
		frame(8'hfe, 3, 3, 8'h30);
		frame(8'h9f, 2, 2, 8'h40);
		drain();
		// each mode reads across both read wrap points
		for (int m = 0; m < 3; m++) begin
			interfaceSelectPin = (m < 2);
			cpol = m[0];
			frame(8'h1e, 3, 0, 8'h00);
			frame(8'h7f, 2, 0, 8'h00);
		end
		stall = 1'b1;
		frame(8'ha0, 4, 3, 8'h50);
		check({15'h0000, wrOverrun}, 16'h0001);
		// frozen core must not pop although the store is ready
		clkEn = 1'b0;
		stall = 1'b0;
		repeat (40) @(posedge ref_clk);
		#1.25;
		check({wrAddr, wrData}, wq[0]);
		clkEn = 1'b1;
		drain();
		frame(8'h8f, 1, 1, 8'h40);
		drain();
		check({14'h0000, wpLock, wrOverrun}, 16'h0002);
		// every noted read address must have been strobed
		check(16'(aq.size()), 16'h0000);
		end_of_test();
	end

	initial begin
		#600000;
		errCount++;
		end_of_test();
	end
endmodule // tb

`default_nettype wire
